/* File: lprtc_pkg.sv */
// Package with register map, field layouts and constants of the calendar clock
package lprtc_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ADR_TIME    = 8'h00;
  localparam logic [7:0] ADR_DATE    = 8'h04;
  localparam logic [7:0] ADR_CTRL    = 8'h08;
  localparam logic [7:0] ADR_SUBSEC  = 8'h0C;
  localparam logic [7:0] ADR_PRESC   = 8'h10;
  localparam logic [7:0] ADR_CALIB   = 8'h14;
  localparam logic [7:0] ADR_SHIFT   = 8'h18;
  localparam logic [7:0] ADR_ALRM_A  = 8'h1C;
  localparam logic [7:0] ADR_ALRM_B  = 8'h20;
  localparam logic [7:0] ADR_WUT     = 8'h24;
  localparam logic [7:0] ADR_TAMPCFG = 8'h28;
  localparam logic [7:0] ADR_TS_TIME = 8'h2C;
  localparam logic [7:0] ADR_TS_DATE = 8'h30;
  localparam logic [7:0] ADR_STATUS  = 8'h34;
  localparam logic [7:0] ADR_MASK    = 8'h38;
  localparam logic [7:0] ADR_BKP0    = 8'h40;

  // ==========================================================================
  // Sizes, reset values and event positions
  localparam int         NUM_BKP      = 5;
  localparam int         NUM_EV       = 6;
  localparam int         EV_ALRM_A    = 0;
  localparam int         EV_ALRM_B    = 1;
  localparam int         EV_WUT       = 2;
  localparam int         EV_TAMP0     = 3;
  localparam int         EV_TS        = 5;
  localparam logic [6:0] RST_PRE_A    = 7'h7F;
  localparam logic [14:0] RST_PRE_S   = 15'h00FF;
  localparam logic [15:0] RST_WUT     = 16'hFFFF;
  localparam logic [5:0] REF_LAST_50  = 6'h31;
  localparam logic [5:0] REF_LAST_60  = 6'h3B;
  localparam logic [7:0] DATE_RST     = 8'h01;
  localparam logic [2:0] WDAY_RST     = 3'h1;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [6:0] pad;
    logic       pm;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } lprtc_time_s;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [4:0] pad;
    logic [2:0] wday;
  } lprtc_date_s;

  typedef struct packed {
    logic       ign_date;
    logic [6:0] date;
    logic       ign_hour;
    logic [6:0] hour;
    logic       ign_min;
    logic [6:0] min;
    logic       ign_sec;
    logic [6:0] sec;
  } lprtc_alarm_s;

  typedef struct packed {
    logic [17:0] pad;
    logic [1:0]  tamp_en;
    logic        ts_en;
    logic        tamp_ts;
    logic [1:0]  wut_div;
    logic        alrm_b_en;
    logic        alrm_a_en;
    logic        wut_en;
    logic        ref_60;
    logic        ref_en;
    logic        fmt12;
    logic [1:0]  clk_src;
  } lprtc_ctrl_s;

endpackage : lprtc_pkg

/* File: lprtc_top.sv */
// Calendar real-time clock with alarms, wakeup timer, tamper, timestamp and backup words
// What this block does
// - Five 32-bit backup words, twenty bytes, writable and readable by software.
// - Backup words are not cleared by system reset or by waking from standby.
// - Calendar keeps binary subseconds and seconds to year in BCD, hours in 12 or 24 format.
// - Date wraps at 28, 29 in leap years, 30 or 31 days.
// - Two independent alarms, each able to wake the device.
// - Periodic wakeup timer with programmable resolution and period.
// - Running clock accepts a shift of 1 to 32767 counted pulses.
// - Optional 50 or 60 Hz reference clock supplies the seconds.
// - Digital calibration removes counted pulses in roughly 1 ppm steps.
// - Two filtered tamper inputs, each event able to wake the device.
// - Timestamp captures calendar on timestamp pin event or tamper event.
// - Timestamp event is able to wake the device.
// - Counting clock chosen from crystal, resonator, internal RC or fast external.
// - Calendar keeps counting while the core is stopped; only backup reset clears it.
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
module lprtc_top (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        bkp_rst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        slow_crystal_clock_i,
  input  wire logic        resonator_clock_i,
  input  wire logic        slow_internal_rc_clock_i,
  input  wire logic        fast_external_clock_i,
  input  wire logic        ref_clock_i,
  input  wire logic [1:0]  tamper_i,
  input  wire logic        timestamp_i,
  output logic             irq_o,
  output logic             wakeup_o
);

  // ==========================================================================
  // Pin synchronisers and edge detection
  logic [7:0] pin_raw;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] sync3_q;
  logic [7:0] rise;

  assign pin_raw = {timestamp_i, tamper_i, ref_clock_i, fast_external_clock_i,
                    slow_internal_rc_clock_i, resonator_clock_i, slow_crystal_clock_i};

  // On the backup reset so a system reset does not drop counting edges
  for (genvar i = 0; i < 8; i++) begin : g_sync
    always_ff @(posedge sys_clk_i or negedge bkp_rst_n_i) begin
      if (!bkp_rst_n_i) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
        sync3_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
      end
    end
    assign rise[i] = sync2_q[i] & ~sync3_q[i];
  end

  // ==========================================================================
  // Configuration and bus decode
  lprtc_pkg::lprtc_ctrl_s  ctrl_q;
  lprtc_pkg::lprtc_time_s  tm_q;
  lprtc_pkg::lprtc_time_s  tm_n;
  lprtc_pkg::lprtc_time_s  ts_tm_q;
  lprtc_pkg::lprtc_date_s  dt_q;
  lprtc_pkg::lprtc_date_s  dt_n;
  lprtc_pkg::lprtc_date_s  ts_dt_q;
  lprtc_pkg::lprtc_alarm_s alrm_q [2];
  logic [31:0] bkp_q [lprtc_pkg::NUM_BKP];
  logic [6:0]  pre_a_q;
  logic [14:0] pre_s_q;
  logic [6:0]  cnt_a_q;
  logic [14:0] cnt_s_q;
  logic [8:0]  calm_q;
  logic [19:0] cal_win_q;
  logic [14:0] shift_q;
  logic        add1s_q;
  logic [15:0] wut_rld_q;
  logic [15:0] wut_cnt_q;
  logic [3:0]  wut_div_q;
  logic [5:0]  ref_cnt_q;
  logic [3:0]  tflt_q;
  logic [3:0]  tcnt_q [2];
  logic [5:0]  st_q;
  logic [5:0]  mask_q;
  logic [5:0]  ev;
  logic        ack_q;
  logic        acc;
  logic        wr;
  logic        rd_st;

  assign acc   = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr    = acc & wb_we_i;
  assign rd_st = acc & ~wb_we_i & (wb_adr_i == lprtc_pkg::ADR_STATUS);

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // Year is BCD 00..99; divisible by four when tens parity matches the units.
  function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    unique case (mon)
      8'h02:                      return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default:                    return 8'h31;
    endcase
  endfunction : month_len

  // ==========================================================================
  // Counting pulse: source select, calibration, shift
  logic raw_pulse;
  logic drop;
  logic pulse;
  logic spre;
  logic ref_tick;
  logic sec_tick;

  always_comb begin
    unique case (ctrl_q.clk_src)
      2'h0:    raw_pulse = rise[0];
      2'h1:    raw_pulse = rise[1];
      2'h2:    raw_pulse = rise[2];
      default: raw_pulse = rise[3];
    endcase
  end

  // Dropping calm pulses per 2^20 window gives about 0.95 ppm per step
  assign drop     = (cal_win_q < {11'h000, calm_q}) | (shift_q != 15'h0000);
  assign pulse    = raw_pulse & ~drop;
  assign spre     = pulse & (cnt_a_q == 7'h00) & (cnt_s_q == 15'h0000);
  assign ref_tick = rise[4] & (ref_cnt_q == (ctrl_q.ref_60 ? lprtc_pkg::REF_LAST_60
                                                           : lprtc_pkg::REF_LAST_50));
  assign sec_tick = (ctrl_q.ref_en ? ref_tick : spre) | add1s_q;

  always_ff @(posedge sys_clk_i or negedge bkp_rst_n_i) begin
    if (!bkp_rst_n_i) begin
      cal_win_q <= 20'h00000;
      shift_q   <= 15'h0000;
      add1s_q   <= 1'b0;
      ref_cnt_q <= 6'h00;
    end else begin
      if (raw_pulse) begin
        cal_win_q <= cal_win_q + 20'h00001;
      end
      if (wr && wb_adr_i == lprtc_pkg::ADR_SHIFT) begin
        shift_q <= wb_dat_i[14:0];
        add1s_q <= wb_dat_i[31];
      end else begin
        add1s_q <= 1'b0;
        if (raw_pulse && shift_q != 15'h0000) begin
          shift_q <= shift_q - 15'h0001;
        end
      end
      if (!ctrl_q.ref_en || ref_tick) begin
        ref_cnt_q <= 6'h00;
      end else if (rise[4]) begin
        ref_cnt_q <= ref_cnt_q + 6'h01;
      end
    end
  end

  // Prescalers: the synchronous down-counter is the subsecond value
  always_ff @(posedge sys_clk_i or negedge bkp_rst_n_i) begin
    if (!bkp_rst_n_i) begin
      cnt_a_q <= lprtc_pkg::RST_PRE_A;
      cnt_s_q <= lprtc_pkg::RST_PRE_S;
    end else if (pulse) begin
      if (cnt_a_q != 7'h00) begin
        cnt_a_q <= cnt_a_q - 7'h01;
      end else begin
        cnt_a_q <= pre_a_q;
        cnt_s_q <= (cnt_s_q == 15'h0000) ? pre_s_q : cnt_s_q - 15'h0001;
      end
    end
  end

  // ==========================================================================
  // Calendar next value
  always_comb begin
    logic day;
    day  = 1'b0;
    tm_n = tm_q;
    dt_n = dt_q;
    if (tm_q.sec != 8'h59) begin
      tm_n.sec = bcd_inc(tm_q.sec);
    end else begin
      tm_n.sec = 8'h00;
      if (tm_q.min != 8'h59) begin
        tm_n.min = bcd_inc(tm_q.min);
      end else begin
        tm_n.min = 8'h00;
        if (ctrl_q.fmt12) begin
          if (tm_q.hour == 8'h12) begin
            tm_n.hour = 8'h01;
          end else begin
            tm_n.hour = bcd_inc(tm_q.hour);
            if (tm_q.hour == 8'h11) begin
              tm_n.pm = ~tm_q.pm;
              day     = tm_q.pm;
            end
          end
        end else if (tm_q.hour == 8'h23) begin
          tm_n.hour = 8'h00;
          day       = 1'b1;
        end else begin
          tm_n.hour = bcd_inc(tm_q.hour);
        end
      end
    end
    if (day) begin
      dt_n.wday = (dt_q.wday == 3'h7) ? 3'h1 : dt_q.wday + 3'h1;
      if (dt_q.date != month_len(dt_q.month, dt_q.year)) begin
        dt_n.date = bcd_inc(dt_q.date);
      end else begin
        dt_n.date = 8'h01;
        if (dt_q.month == 8'h12) begin
          dt_n.month = 8'h01;
          dt_n.year  = (dt_q.year == 8'h99) ? 8'h00 : bcd_inc(dt_q.year);
        end else begin
          dt_n.month = bcd_inc(dt_q.month);
        end
      end
    end
  end

  // Calendar and settings sit on the backup reset so a system reset leaves them running
  always_ff @(posedge sys_clk_i or negedge bkp_rst_n_i) begin
    if (!bkp_rst_n_i) begin
      tm_q      <= '0;
      dt_q      <= '{year: 8'h00, month: lprtc_pkg::DATE_RST, date: lprtc_pkg::DATE_RST,
                     pad: 5'h00, wday: lprtc_pkg::WDAY_RST};
      ctrl_q    <= '0;
      pre_a_q   <= lprtc_pkg::RST_PRE_A;
      pre_s_q   <= lprtc_pkg::RST_PRE_S;
      calm_q    <= 9'h000;
      wut_rld_q <= lprtc_pkg::RST_WUT;
      tflt_q    <= 4'h0;
      alrm_q[0] <= '0;
      alrm_q[1] <= '0;
    end else begin
      if (wr && wb_adr_i == lprtc_pkg::ADR_TIME) begin
        tm_q <= merge(tm_q, wb_dat_i, wb_sel_i);
      end else if (sec_tick) begin
        tm_q <= tm_n;
      end
      if (wr && wb_adr_i == lprtc_pkg::ADR_DATE) begin
        dt_q <= merge(dt_q, wb_dat_i, wb_sel_i);
      end else if (sec_tick) begin
        dt_q <= dt_n;
      end
      if (wr) begin
        unique case (wb_adr_i)
          lprtc_pkg::ADR_CTRL:    ctrl_q    <= merge(ctrl_q, wb_dat_i, wb_sel_i);
          lprtc_pkg::ADR_PRESC:   {pre_a_q, pre_s_q} <= {wb_dat_i[22:16], wb_dat_i[14:0]};
          lprtc_pkg::ADR_CALIB:   calm_q    <= wb_dat_i[8:0];
          lprtc_pkg::ADR_ALRM_A:  alrm_q[0] <= merge(alrm_q[0], wb_dat_i, wb_sel_i);
          lprtc_pkg::ADR_ALRM_B:  alrm_q[1] <= merge(alrm_q[1], wb_dat_i, wb_sel_i);
          lprtc_pkg::ADR_WUT:     wut_rld_q <= wb_dat_i[15:0];
          lprtc_pkg::ADR_TAMPCFG: tflt_q    <= wb_dat_i[3:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Backup words: no reset at all, so neither reset nor standby exit clears them
  for (genvar k = 0; k < lprtc_pkg::NUM_BKP; k++) begin : g_bkp
    always_ff @(posedge sys_clk_i) begin
      if (wr && wb_adr_i == lprtc_pkg::ADR_BKP0 + 8'(4 * k)) begin
        bkp_q[k] <= merge(bkp_q[k], wb_dat_i, wb_sel_i);
      end
    end
  end

  // ==========================================================================
  // Alarms, wakeup timer, tamper filters, timestamp
  logic [1:0] alrm_hit;
  logic       wtick;
  logic       wut_ev;
  logic [1:0] tamp_ev;
  logic       ts_ev;

  for (genvar a = 0; a < 2; a++) begin : g_alrm
    assign alrm_hit[a] = sec_tick
      & (alrm_q[a].ign_sec  | (alrm_q[a].sec  == tm_n.sec[6:0]))
      & (alrm_q[a].ign_min  | (alrm_q[a].min  == tm_n.min[6:0]))
      & (alrm_q[a].ign_hour | (alrm_q[a].hour == {tm_n.pm, tm_n.hour[5:0]}))
      & (alrm_q[a].ign_date | (alrm_q[a].date == dt_n.date[6:0]));
  end

  assign wtick = (ctrl_q.wut_div == 2'h3) ? sec_tick
               : pulse & ((wut_div_q | {1'b0, ctrl_q.wut_div == 2'h2, 2'h0}
                           | {ctrl_q.wut_div != 2'h0, 3'h0}) == 4'hF);
  assign wut_ev = ctrl_q.wut_en & wtick & (wut_cnt_q == 16'h0000);

  always_ff @(posedge sys_clk_i or negedge bkp_rst_n_i) begin
    if (!bkp_rst_n_i) begin
      wut_div_q <= 4'h0;
      wut_cnt_q <= lprtc_pkg::RST_WUT;
    end else begin
      if (pulse) begin
        wut_div_q <= wut_div_q + 4'h1;
      end
      if (!ctrl_q.wut_en || wut_ev) begin
        wut_cnt_q <= wut_rld_q;
      end else if (wtick) begin
        wut_cnt_q <= wut_cnt_q - 16'h0001;
      end
    end
  end

  // Input must stay high for 1, 2, 4 or 8 samples; a short glitch is ignored
  for (genvar t = 0; t < 2; t++) begin : g_tamp
    logic [3:0] lim;
    assign lim        = 4'h1 << tflt_q[2*t +: 2];
    assign tamp_ev[t] = ctrl_q.tamp_en[t] & sync2_q[5 + t] & (tcnt_q[t] == lim - 4'h1);
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        tcnt_q[t] <= 4'h0;
      end else if (!sync2_q[5 + t] || !ctrl_q.tamp_en[t]) begin
        tcnt_q[t] <= 4'h0;
      end else if (tcnt_q[t] != lim) begin
        tcnt_q[t] <= tcnt_q[t] + 4'h1;
      end
    end
  end

  assign ts_ev = (ctrl_q.ts_en & rise[7]) | (ctrl_q.tamp_ts & |tamp_ev);

  always_ff @(posedge sys_clk_i or negedge bkp_rst_n_i) begin
    if (!bkp_rst_n_i) begin
      ts_tm_q <= '0;
      ts_dt_q <= '0;
    end else if (ts_ev) begin
      ts_tm_q <= tm_q;
      ts_dt_q <= dt_q;
    end
  end

  // ==========================================================================
  // Status, mask and interrupt; a new event outranks the read that clears
  assign ev = {ts_ev, tamp_ev, wut_ev, alrm_hit & {ctrl_q.alrm_b_en, ctrl_q.alrm_a_en}};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q     <= 6'h00;
      mask_q   <= 6'h00;
      irq_o    <= 1'b0;
      wakeup_o <= 1'b0;
    end else begin
      st_q <= (st_q & ~{6{rd_st}}) | ev;
      if (wr && wb_adr_i == lprtc_pkg::ADR_MASK) begin
        mask_q <= wb_dat_i[5:0];
      end
      irq_o    <= |(st_q & mask_q);
      wakeup_o <= |st_q;
    end
  end

  // ==========================================================================
  // Wishbone answer: ack one cycle after the request, unmapped reads give zero
  logic [31:0] rdat;

  always_comb begin
    rdat = 32'h0000_0000;
    unique case (wb_adr_i)
      lprtc_pkg::ADR_TIME:    rdat = tm_q;
      lprtc_pkg::ADR_DATE:    rdat = dt_q;
      lprtc_pkg::ADR_CTRL:    rdat = ctrl_q;
      lprtc_pkg::ADR_SUBSEC:  rdat = {17'h00000, cnt_s_q};
      lprtc_pkg::ADR_PRESC:   rdat = {9'h000, pre_a_q, 1'b0, pre_s_q};
      lprtc_pkg::ADR_CALIB:   rdat = {23'h000000, calm_q};
      lprtc_pkg::ADR_SHIFT:   rdat = {17'h00000, shift_q};
      lprtc_pkg::ADR_ALRM_A:  rdat = alrm_q[0];
      lprtc_pkg::ADR_ALRM_B:  rdat = alrm_q[1];
      lprtc_pkg::ADR_WUT:     rdat = {wut_cnt_q, wut_rld_q};
      lprtc_pkg::ADR_TAMPCFG: rdat = {28'h0000000, tflt_q};
      lprtc_pkg::ADR_TS_TIME: rdat = ts_tm_q;
      lprtc_pkg::ADR_TS_DATE: rdat = ts_dt_q;
      lprtc_pkg::ADR_STATUS:  rdat = {26'h0000000, st_q};
      lprtc_pkg::ADR_MASK:    rdat = {26'h0000000, mask_q};
      default: begin
        for (int k = 0; k < lprtc_pkg::NUM_BKP; k++) begin
          if (wb_adr_i == lprtc_pkg::ADR_BKP0 + 8'(4 * k)) begin
            rdat = bkp_q[k];
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q    <= acc;
      wb_dat_o <= acc ? rdat : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;

endmodule : lprtc_top

/* File: lprtc_top_assertions.sv */
// Concurrent checks on the bus, interrupt and wakeup ports of the calendar clock
`timescale 1ns/10ps
module lprtc_top_assertions (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq_o,
  input wire logic        wakeup_o
);
  // ====================
  // Helpers
  logic req;
  logic st_acc;
  logic clr_acc;
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign st_acc  = req && (wb_adr_i == lprtc_pkg::ADR_STATUS);
  assign clr_acc = st_acc || (req && (wb_adr_i == lprtc_pkg::ADR_MASK));
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ====================
  // Properties
  chk_ack_next_cycle: assert property (req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_unmapped_read_zero: assert property (req && !wb_we_i && wb_adr_i == 8'h3C
    |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_implies_wake: assert property (irq_o |-> wakeup_o)
    else $error("irq without pending event");
  chk_reset_quiet: assert property ($rose(rst_n_i) |-> !wb_ack_o && !irq_o && !wakeup_o)
    else $error("outputs active after reset");
  // Only a status access may clear a pending event; the two flops add two cycles of lag, the checks allow three
  chk_wake_sticky: assert property ($fell(wakeup_o)
    |-> $past(st_acc, 1) || $past(st_acc, 2) || $past(st_acc, 3))
    else $error("wakeup dropped without status read");
  chk_irq_sticky: assert property ($fell(irq_o)
    |-> $past(clr_acc, 1) || $past(clr_acc, 2) || $past(clr_acc, 3))
    else $error("irq dropped without status or mask access");
endmodule : lprtc_top_assertions

bind lprtc_top lprtc_top_assertions u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .wakeup_o(wakeup_o));

/* File: lprtc_partner.sv */
// Far-side model: slow crystal source, tamper and timestamp pins
`timescale 1ns/10ps
module lprtc_partner (
  input  wire logic  sys_clk_i,
  output logic       slow_clk_o,
  output logic [1:0] tamper_o,
  output logic       ts_o
);
  logic [2:0] div_q = 3'h0;
  initial begin
    slow_clk_o = 1'b0;
    tamper_o   = 2'h0;
    ts_o       = 1'b0;
  end
  // Free-running 10 MHz source; a crystal never stops, so the calendar keeps counting
  always @(posedge sys_clk_i) begin
    div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
    if (div_q == 3'h4) slow_clk_o <= ~slow_clk_o;
  end
  // Index 0 and 1 are tamper lines, 2 the timestamp pin
  task automatic pulse(input int idx, input int cycles);
    if (idx < 2) tamper_o[idx] <= 1'b1;
    else ts_o <= 1'b1;
    repeat (cycles) @(posedge sys_clk_i);
    if (idx < 2) tamper_o[idx] <= 1'b0;
    else ts_o <= 1'b0;
  endtask : pulse
endmodule : lprtc_partner

/* File: lprtc_top_tb.sv */
// Self-checking testbench of the calendar clock
`timescale 1ns/10ps
module lprtc_top_tb;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        bkp_rst_n_i = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic        ack, irq, wake, slow_clk, ts;
  logic [1:0]  tamper;
  int          fails = 0;
  int          num_checks = 0;
  // Rows: ctrl, time in, date in, time after tick, date after tick
  logic [31:0] tab [5][5] = '{
    '{32'h0, 32'h00235959, 32'h01022803, 32'h00000000, 32'h01030104},
    '{32'h0, 32'h00235959, 32'h04022807, 32'h00000000, 32'h04022901},
    '{32'h0, 32'h00235959, 32'h04043002, 32'h00000000, 32'h04050103},
    '{32'h0, 32'h00235959, 32'h99123105, 32'h00000000, 32'h00010106},
    '{32'h4, 32'h00115959, 32'h01010101, 32'h01120000, 32'h01010101}};

  always #5 sys_clk_i = ~sys_clk_i;

  lprtc_partner u_far (.sys_clk_i(sys_clk_i), .slow_clk_o(slow_clk), .tamper_o(tamper),
    .ts_o(ts));
  lprtc_top dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bkp_rst_n_i(bkp_rst_n_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .slow_crystal_clock_i(slow_clk),
    .resonator_clock_i(1'b0), .slow_internal_rc_clock_i(1'b0),
    .fast_external_clock_i(1'b0), .ref_clock_i(1'b0), .tamper_i(tamper),
    .timestamp_i(ts), .irq_o(irq), .wakeup_o(wake));

  // ====================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_w <= d;
    @(posedge sys_clk_i);
    while (ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge sys_clk_i);
    end
    if (n == 20) check({31'h0, ack}, 32'h1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  // Polls until the time word moves on; bounded so a dead prescaler cannot hang
  task automatic wait_tick(input logic [31:0] t, output logic [31:0] q);
    int n;
    n = 0;
    q = t;
    while (q === t && n < 5000) begin
      rd(lprtc_pkg::ADR_TIME, q);
      n++;
    end
  endtask : wait_tick

  // ====================
  // Scenarios
  task automatic t_backup();
    logic [31:0] q;
    for (int i = 0; i < lprtc_pkg::NUM_BKP; i++) wr(lprtc_pkg::ADR_BKP0 + 8'(4*i), {8'hA5, 24'(i)});
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    for (int i = 0; i < lprtc_pkg::NUM_BKP; i++) begin
      rd(lprtc_pkg::ADR_BKP0 + 8'(4*i), q);
      check(q, {8'hA5, 24'(i)});
    end
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, q);
    check(q, 32'h0);
  endtask : t_backup

  task automatic t_calendar();
    logic [31:0] q;
    // Sixteen source edges a second keeps each rollover short; the first tick
    // still waits for the reset prescaler count to run out
    wr(lprtc_pkg::ADR_PRESC, 32'h00030003);
    for (int r = 0; r < 5; r++) begin
      wr(lprtc_pkg::ADR_CTRL, tab[r][0]);
      wr(lprtc_pkg::ADR_DATE, tab[r][2]);
      wr(lprtc_pkg::ADR_TIME, tab[r][1]);
      wait_tick(tab[r][1], q);
      check(q, tab[r][3]);
      rd(lprtc_pkg::ADR_DATE, q);
      check(q, tab[r][4]);
    end
  endtask : t_calendar

  task automatic t_alarm();
    logic [31:0] q;
    wr(lprtc_pkg::ADR_CTRL, 32'h000000C0);
    wr(lprtc_pkg::ADR_ALRM_A, 32'h80808000);
    wr(lprtc_pkg::ADR_ALRM_B, 32'h80808000);
    for (int m = 1; m >= 0; m--) begin
      wr(lprtc_pkg::ADR_MASK, {31'h0, 1'(m)});
      rd(lprtc_pkg::ADR_STATUS, q);
      wr(lprtc_pkg::ADR_TIME, 32'h00000059);
      wait_tick(32'h00000059, q);
      repeat (3) @(posedge sys_clk_i);
      check({31'h0, irq}, {31'h0, 1'(m)});
      check({31'h0, wake}, 32'h1);
      rd(lprtc_pkg::ADR_STATUS, q);
      check(q, 32'h3);
      rd(lprtc_pkg::ADR_STATUS, q);
      check(q, 32'h0);
    end
  endtask : t_alarm

  task automatic t_stamp();
    logic [31:0] q, t;
    wr(lprtc_pkg::ADR_CTRL, 32'h00001C00);
    wr(lprtc_pkg::ADR_TAMPCFG, 32'h0);
    rd(lprtc_pkg::ADR_STATUS, q);
    // Stamp just after a tick so the time cannot move before it is read
    rd(lprtc_pkg::ADR_TIME, t);
    wait_tick(t, t);
    u_far.pulse(2, 4);
    repeat (4) @(posedge sys_clk_i);
    rd(lprtc_pkg::ADR_TS_TIME, q);
    check(q, t);
    rd(lprtc_pkg::ADR_STATUS, q);
    check(q, 32'h20);
    u_far.pulse(0, 10);
    repeat (8) @(posedge sys_clk_i);
    check({31'h0, wake}, 32'h1);
    rd(lprtc_pkg::ADR_STATUS, q);
    check(q & 32'h8, 32'h8);
  endtask : t_stamp

  task automatic t_wakeup();
    logic [31:0] q;
    // Reload of zero with the one-second resolution fires on every tick
    wr(lprtc_pkg::ADR_WUT, 32'h0);
    wr(lprtc_pkg::ADR_CTRL, 32'h00000320);
    rd(lprtc_pkg::ADR_STATUS, q);
    rd(lprtc_pkg::ADR_TIME, q);
    wait_tick(q, q);
    repeat (3) @(posedge sys_clk_i);
    rd(lprtc_pkg::ADR_STATUS, q);
    check(q, 32'h4);
  endtask : t_wakeup

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    bkp_rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_backup();
    t_calendar();
    t_alarm();
    t_stamp();
    t_wakeup();
    finish_test();
  end

  initial begin
    #500000;
    fails++;
    finish_test();
  end
endmodule : lprtc_top_tb
